// file: design/pdsc_regs.vh
`ifndef PDSC_REGS_VH
`define PDSC_REGS_VH

// apb register byte addresses
`define PDSC_ADDR_CTRL      12'h000
`define PDSC_ADDR_STATUS    12'h004
`define PDSC_ADDR_IRQ_STAT  12'h008
`define PDSC_ADDR_IRQ_MASK  12'h00C
`define PDSC_ADDR_SC_CFG    12'h010

// control register fields
`define PDSC_CTRL_SW_RESET  0
`define PDSC_CTRL_RESET     32'h00000000

// status register fields
`define PDSC_ST_DCDC_RST    0
`define PDSC_ST_SOFTSTART   1
`define PDSC_ST_SYNC_EN     2
`define PDSC_ST_INRUSH_EN   3
`define PDSC_ST_KEEPALIVE   4
`define PDSC_ST_AUTO_MODE   5
`define PDSC_ST_SLEEPING    6
`define PDSC_ST_OPT_LATCH   7
`define PDSC_ST_FIXED_OSC   8

// interrupt event bits
`define PDSC_EV_OVERCURRENT 0
`define PDSC_EV_SHORT       1
`define PDSC_EV_LOWCURRENT  2
`define PDSC_EV_SLEEP       3
`define PDSC_EV_WAKE        4
`define PDSC_EV_W           5
`define PDSC_EV_NONE        5'h00

// timing: clock 200 MHz, short timeout 1 ms, soft start 1 ms
`define PDSC_CLK_HZ         200000000
`define PDSC_SHORT_TIME_US  1000
`define PDSC_SOFTSTART_US   1000
`define PDSC_CNT_W          20
`define PDSC_CNT_ZERO       20'h00000
`define PDSC_CNT_ONE        20'h00001
`define PDSC_HZ_PER_MHZ     1000000

// synchroniser reset levels, sleep entry pin idles high
`define PDSC_SYNC_IDLE      11'h040

`endif

// file: design/pdsc_sleep_protect.v
// Our own choices: the address map and the APB interface to the registers.
`include "pdsc_regs.vh"

// Function
// - While the overcurrent comparator is tripped the dc-dc controller is held in reset.
// - When overcurrent clears the controller is released through a full soft start.
// - Average current below the low-current threshold turns off sync and inrush switch drivers.
// - Internal current below keepalive limit with automatic sleep enabled starts pulses.
// - Error amp output high for more than 1 ms resets the controller and starts soft start.
// - The sync rectifier driver is on by default and off only during low average current.
// - Frequency pin shorted to the rail selects the fixed oscillator, else the resistor.
// - Sleep request tied low gives automatic sleep with pulses whenever consumption is low.
// - Sleep request tied high gives no pulses even when consumption is low.
// - Sleep request high at switch turn-on disables auto mode; pulses follow the input low.
// - In special sleep mode a falling edge of sleep entry enters sleep.
// - At that edge sleep state and sleep option latch and hold until wakeup.
// - During special sleep pulses are enabled only if the latched option was 0.
// - An asserted wake input leaves special sleep.
module pdsc_sleep_protect #(
	parameter SHORT_CYCLES = `PDSC_CLK_HZ / `PDSC_HZ_PER_MHZ * `PDSC_SHORT_TIME_US,
	parameter SOFT_CYCLES  = `PDSC_CLK_HZ / `PDSC_HZ_PER_MHZ * `PDSC_SOFTSTART_US
) (
	input  wire        clk_i,
	input  wire        arst_n_i,
	input  wire        overcurrent_i,
	input  wire        low_current_i,
	input  wire        keepalive_low_i,
	input  wire        error_amp_output_i,
	input  wire        freq_set_pin_shorted_i,
	input  wire        sleep_request_n_i,
	input  wire        sleep_entry_n_i,
	input  wire        sleep_option_i,
	input  wire        wake_i,
	input  wire        special_mode_i,
	input  wire        hotswap_on_i,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	output reg         dcdc_reset_o,
	output reg         softstart_o,
	output reg         sync_rectifier_gate_en_o,
	output reg         ext_inrush_switch_gate_en_o,
	output reg         keepalive_pulse_en_o,
	output reg         fixed_osc_sel_o,
	output wire        irq_o
);

	// synchroniser width, idle levels and timing limits
	localparam NSYNC = 11;
	localparam [NSYNC-1:0]       SYNC_IDLE = `PDSC_SYNC_IDLE;
	localparam [`PDSC_CNT_W-1:0] SHORT_LIM = SHORT_CYCLES[`PDSC_CNT_W-1:0];
	localparam [`PDSC_CNT_W-1:0] SOFT_LIM  = SOFT_CYCLES[`PDSC_CNT_W-1:0];

	// run states, one-hot
	localparam [2:0] ST_RUN  = 3'b001;
	localparam [2:0] ST_HOLD = 3'b010;
	localparam [2:0] ST_SOFT = 3'b100;

	// input synchronisers and their aliases
	reg  [NSYNC-1:0] meta_reg;
	reg  [NSYNC-1:0] sync_reg;
	wire [NSYNC-1:0] raw_in;
	wire             oc_s;
	wire             lc_s;
	wire             ka_s;
	wire             ea_s;
	wire             fq_s;
	wire             sr_s;
	wire             se_s;
	wire             opt_s;
	wire             wk_s;
	wire             sp_s;
	wire             hs_s;

	// converter state and counters
	reg  [2:0]            state_reg;
	reg  [2:0]            state_next;
	reg  [`PDSC_CNT_W-1:0] short_cnt_reg;
	reg  [`PDSC_CNT_W-1:0] soft_cnt_reg;
	reg  [`PDSC_CNT_W-1:0] soft_cnt_next;
	// sleep mode state
	reg                    hs_prev_reg;
	reg                    se_prev_reg;
	reg                    auto_mode_reg;
	reg                    sleeping_reg;
	reg                    opt_latch_reg;
	// register file and bus
	reg                    ctrl_reg;
	reg  [`PDSC_EV_W-1:0]  irq_stat_reg;
	reg  [`PDSC_EV_W-1:0]  irq_mask_reg;
	reg  [31:0]            rdata_reg;
	reg                    ka_next;
	wire                   short_trip;
	wire                   sleep_fall;
	wire                   wr_en;
	wire [`PDSC_EV_W-1:0]  events;
	wire [31:0]            status_word;

	// pin vector, bit order matches the aliases below
	assign raw_in = {hotswap_on_i, special_mode_i, wake_i, sleep_option_i, sleep_entry_n_i,
		sleep_request_n_i, freq_set_pin_shorted_i, error_amp_output_i, keepalive_low_i,
		low_current_i, overcurrent_i};

	// two-flop synchronisers for all pin inputs
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
			always @(posedge clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					meta_reg[gi] <= SYNC_IDLE[gi];
					sync_reg[gi] <= SYNC_IDLE[gi];
				end else begin
					meta_reg[gi] <= raw_in[gi];
					sync_reg[gi] <= meta_reg[gi];
				end
			end
		end
	endgenerate

	// synchronised pin aliases
	assign oc_s  = sync_reg[0];
	assign lc_s  = sync_reg[1];
	assign ka_s  = sync_reg[2];
	assign ea_s  = sync_reg[3];
	assign fq_s  = sync_reg[4];
	assign sr_s  = sync_reg[5];
	assign se_s  = sync_reg[6];
	assign opt_s = sync_reg[7];
	assign wk_s  = sync_reg[8];
	assign sp_s  = sync_reg[9];
	assign hs_s  = sync_reg[10];

	// short timer trips strictly beyond the limit
	assign short_trip = (short_cnt_reg > SHORT_LIM);
	// special sleep entry edge, ignored while asleep
	assign sleep_fall = sp_s & se_prev_reg & ~se_s & ~sleeping_reg;

	// converter run state machine
	always @* begin
		state_next    = state_reg;
		soft_cnt_next = soft_cnt_reg;
		case (state_reg)
			ST_RUN: begin
				if (oc_s || short_trip || ctrl_reg)
					state_next = ST_HOLD;
			end
			ST_HOLD: begin
				if (!oc_s && !ctrl_reg) begin
					state_next    = ST_SOFT;
					soft_cnt_next = `PDSC_CNT_ZERO;
				end
			end
			ST_SOFT: begin
				if (oc_s || short_trip || ctrl_reg)
					state_next = ST_HOLD;
				else if (soft_cnt_reg >= SOFT_LIM)
					state_next = ST_RUN;
				else
					soft_cnt_next = soft_cnt_reg + `PDSC_CNT_ONE;
			end
			default: state_next = ST_HOLD;
		endcase
	end

	// keepalive pulse selection
	always @* begin
		if (sleeping_reg)
			ka_next = ~opt_latch_reg;
		else if (auto_mode_reg)
			ka_next = ka_s & ~sr_s;
		else
			ka_next = ~sr_s;
	end

	// run state and soft start counter
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg    <= ST_HOLD;
			soft_cnt_reg <= `PDSC_CNT_ZERO;
		end else begin
			state_reg    <= state_next;
			soft_cnt_reg <= soft_cnt_next;
		end
	end

	// count high error amp, clear on low or trip
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			short_cnt_reg <= `PDSC_CNT_ZERO;
		end else if (!ea_s || short_trip) begin
			short_cnt_reg <= `PDSC_CNT_ZERO;
		end else begin
			short_cnt_reg <= short_cnt_reg + `PDSC_CNT_ONE;
		end
	end

	// mode sampling and special sleep latches
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hs_prev_reg   <= 1'b0;
			se_prev_reg   <= 1'b1;
			auto_mode_reg <= 1'b1;
			sleeping_reg  <= 1'b0;
			opt_latch_reg <= 1'b0;
		end else begin
			hs_prev_reg <= hs_s;
			se_prev_reg <= se_s;
			if (hs_s && !hs_prev_reg)
				auto_mode_reg <= ~sr_s;
			if (wk_s && sleeping_reg) begin
				sleeping_reg  <= 1'b0;
				opt_latch_reg <= 1'b0;
			end else if (sleep_fall) begin
				sleeping_reg  <= 1'b1;
				opt_latch_reg <= opt_s;
			end
		end
	end

	// registered pin outputs
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dcdc_reset_o                <= 1'b1;
			softstart_o                 <= 1'b0;
			sync_rectifier_gate_en_o    <= 1'b1;
			ext_inrush_switch_gate_en_o <= 1'b1;
			keepalive_pulse_en_o        <= 1'b0;
			fixed_osc_sel_o             <= 1'b0;
		end else begin
			// reset and soft start follow next state
			dcdc_reset_o <= (state_next == ST_HOLD);
			softstart_o  <= (state_next == ST_SOFT);
			sync_rectifier_gate_en_o    <= ~lc_s;
			ext_inrush_switch_gate_en_o <= ~lc_s;
			keepalive_pulse_en_o        <= ka_next;
			fixed_osc_sel_o <= fq_s;
		end
	end

	// event sources
	assign events = {wk_s & sleeping_reg, sleep_fall, lc_s & sync_rectifier_gate_en_o,
		short_trip, oc_s & ~dcdc_reset_o};

	// apb slave, zero wait states
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign wr_en   = psel & penable & pwrite;
	assign prdata  = rdata_reg;
	assign irq_o   = |(irq_stat_reg & irq_mask_reg);

	// status word layout, bit 8 down to bit 0
	assign status_word = {23'h000000, fixed_osc_sel_o, opt_latch_reg, sleeping_reg,
		auto_mode_reg, keepalive_pulse_en_o, ext_inrush_switch_gate_en_o,
		sync_rectifier_gate_en_o, softstart_o, dcdc_reset_o};

	// register writes; event set wins over w1c
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_reg     <= 1'b0;
			irq_stat_reg <= `PDSC_EV_NONE;
			irq_mask_reg <= `PDSC_EV_NONE;
		end else begin
			if (wr_en && paddr == `PDSC_ADDR_CTRL)
				ctrl_reg <= pwdata[`PDSC_CTRL_SW_RESET];
			if (wr_en && paddr == `PDSC_ADDR_IRQ_MASK)
				irq_mask_reg <= pwdata[`PDSC_EV_W-1:0];
			if (wr_en && paddr == `PDSC_ADDR_IRQ_STAT)
				irq_stat_reg <= (irq_stat_reg & ~pwdata[`PDSC_EV_W-1:0]) | events;
			else
				irq_stat_reg <= irq_stat_reg | events;
		end
	end

	// read mux, registered during setup phase
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_reg <= 32'h00000000;
		end else if (psel && !penable) begin
			case (paddr)
				`PDSC_ADDR_CTRL:     rdata_reg <= {31'h00000000, ctrl_reg};
				`PDSC_ADDR_STATUS:   rdata_reg <= status_word;
				`PDSC_ADDR_IRQ_STAT: rdata_reg <= {27'h0000000, irq_stat_reg};
				`PDSC_ADDR_IRQ_MASK: rdata_reg <= {27'h0000000, irq_mask_reg};
				default:             rdata_reg <= 32'h00000000;
			endcase
		end
	end

endmodule

// file: dv/pdsc_chk.sv
module pdsc_chk #(
	parameter SHORT_CYCLES = 20,
	parameter SOFT_CYCLES  = 20
) (
	input wire clk_i,
	input wire arst_n_i,
	input wire overcurrent_i,
	input wire low_current_i,
	input wire keepalive_low_i,
	input wire error_amp_output_i,
	input wire freq_set_pin_shorted_i,
	input wire sleep_request_n_i,
	input wire special_mode_i,
	input wire psel,
	input wire pready,
	input wire pslverr,
	input wire dcdc_reset_o,
	input wire softstart_o,
	input wire sync_rectifier_gate_en_o,
	input wire ext_inrush_switch_gate_en_o,
	input wire keepalive_pulse_en_o,
	input wire fixed_osc_sel_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	logic [19:0] ea_cnt;
	logic [19:0] ss_cnt;
	logic        trip;
	// run lengths of error amp high and soft start
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ea_cnt <= '0;
			ss_cnt <= '0;
			trip <= 1'b0;
		end else begin
			ea_cnt <= error_amp_output_i ? ea_cnt + 20'h00001 : '0;
			ss_cnt <= softstart_o ? ss_cnt + 20'h00001 : '0;
			trip <= error_amp_output_i && (trip || dcdc_reset_o);
		end
	end
	sequence oc_clear;
		$fell(overcurrent_i) ##1 (!overcurrent_i && !error_amp_output_i)[*4];
	endsequence
	a_ovc_hold_reset: assert property (overcurrent_i[*5] |-> dcdc_reset_o)
		else $error("reset not held");
	a_ovc_soft_start: assert property (oc_clear |-> softstart_o && !dcdc_reset_o)
		else $error("no soft start");
	a_soft_len: assert property (
		$fell(softstart_o) && !dcdc_reset_o |-> ss_cnt == SOFT_CYCLES + 1)
		else $error("soft start length");
	a_short_trip: assert property (ea_cnt == SHORT_CYCLES + 8 |-> trip)
		else $error("short not tripped");
	a_low_cur_off: assert property (low_current_i[*5] |->
		!sync_rectifier_gate_en_o && !ext_inrush_switch_gate_en_o)
		else $error("drivers on");
	a_sync_default: assert property ((!low_current_i)[*5] |-> sync_rectifier_gate_en_o)
		else $error("sync off");
	a_fixed_osc: assert property ($stable(freq_set_pin_shorted_i)[*4] |->
		fixed_osc_sel_o == freq_set_pin_shorted_i)
		else $error("osc select");
	a_apb_clean: assert property (psel |-> pready && !pslverr)
		else $error("apb answer");
	a_no_pulse_high: assert property ((sleep_request_n_i && !special_mode_i)[*5] |->
		!keepalive_pulse_en_o)
		else $error("pulses while high");
	a_auto_pulse: assert property (
		(keepalive_low_i && !sleep_request_n_i && !special_mode_i)[*5]
		|-> keepalive_pulse_en_o)
		else $error("no auto pulses");
endmodule
bind pdsc_sleep_protect pdsc_chk #(
	.SHORT_CYCLES(SHORT_CYCLES),
	.SOFT_CYCLES(SOFT_CYCLES)
) chk_u (.*);

// file: dv/pdsc_app_model.sv
module pdsc_app_model (
	input  wire  clk_i,
	input  wire  go_sleep,
	input  wire  opt_cmd,
	input  wire  wake_cmd,
	output logic sleep_entry_n_i = 1'b1,
	output logic sleep_option_i  = 1'b0,
	output logic wake_i          = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;
	// sleep pins move just after an edge
	always @(posedge clk_i) begin
		sleep_entry_n_i <= !go_sleep;
		sleep_option_i <= opt_cmd;
		wake_i <= wake_cmd;
	end
endmodule

// file: dv/pdsc_sleep_protect_tb.sv
module pdsc_sleep_protect_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SC = 20;
	logic clk_i = '0, arst_n_i = '0, overcurrent_i = '0, low_current_i = '0;
	logic keepalive_low_i = '0, error_amp_output_i = '0, freq_set_pin_shorted_i = '0;
	logic sleep_request_n_i = '0, special_mode_i = '0, hotswap_on_i = '0;
	logic psel = '0, penable = '0, pwrite = '0, go_sleep = '0, opt_cmd = '0, wake_cmd = '0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, rd;
	wire [31:0] prdata;
	wire pready, pslverr, dcdc_reset_o, softstart_o, sync_rectifier_gate_en_o, irq_o;
	wire ext_inrush_switch_gate_en_o, keepalive_pulse_en_o, fixed_osc_sel_o;
	wire sleep_entry_n_i, sleep_option_i, wake_i;
	int n_fail = 0, check_count = 0, cyc = 0;
	pdsc_sleep_protect #(.SHORT_CYCLES(SC), .SOFT_CYCLES(SC)) dut_u (.*);
	pdsc_app_model app_u (.*);
	// clock and hang guard
	always #2.5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			test_done();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// one apb transfer, read data kept in rd
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do @(posedge clk_i); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask
	task automatic t_regs;
		rdchk(12'h004, 32'h1FF, 32'h02C);
		apb(1'b1, 12'h010, 32'hFFFFFFFF);
		rdchk(12'h010, 32'hFFFFFFFF, 32'h0);
		apb(1'b1, 12'h000, 32'h1);
		tick(1);
		chk(dcdc_reset_o, 1'b1);
		apb(1'b1, 12'h000, 32'h0);
		tick(2 * SC + 8);
	endtask
	task automatic t_ovc;
		overcurrent_i <= 1'b1;
		tick(10);
		chk(dcdc_reset_o, 1'b1);
		chk(irq_o, 1'b0);
		apb(1'b1, 12'h00C, 32'h1);
		chk(irq_o, 1'b1);
		overcurrent_i <= 1'b0;
		tick(5);
		chk({dcdc_reset_o, softstart_o}, 2'b01);
		apb(1'b1, 12'h008, 32'h1F);
		chk(irq_o, 1'b0);
		tick(2 * SC);
		chk(softstart_o, 1'b0);
	endtask
	task automatic t_short;
		error_amp_output_i <= 1'b1;
		tick(SC - 6);
		error_amp_output_i <= 1'b0;
		tick(3);
		error_amp_output_i <= 1'b1;
		tick(SC - 6);
		rdchk(12'h008, 32'h2, 32'h0);
		tick(12);
		rdchk(12'h008, 32'h2, 32'h2);
		error_amp_output_i <= 1'b0;
		tick(3 * SC);
		apb(1'b1, 12'h008, 32'h1F);
	endtask
	task automatic t_low;
		low_current_i <= 1'b1;
		keepalive_low_i <= 1'b1;
		tick(6);
		chk({sync_rectifier_gate_en_o, ext_inrush_switch_gate_en_o}, 2'b00);
		chk(keepalive_pulse_en_o, 1'b1);
		sleep_request_n_i <= 1'b1;
		tick(6);
		chk(keepalive_pulse_en_o, 1'b0);
		low_current_i <= 1'b0;
		keepalive_low_i <= 1'b0;
		sleep_request_n_i <= 1'b0;
		tick(6);
		chk({sync_rectifier_gate_en_o, ext_inrush_switch_gate_en_o}, 2'b11);
		for (int i = 1; i >= 0; i--) begin
			freq_set_pin_shorted_i <= i[0];
			tick(6);
			chk(fixed_osc_sel_o, i[0]);
		end
	endtask
	task automatic t_special;
		special_mode_i <= 1'b1;
		for (int o = 0; o < 2; o++) begin
			opt_cmd <= o[0];
			go_sleep <= 1'b1;
			tick(6);
			chk(keepalive_pulse_en_o, !o[0]);
			opt_cmd <= !o[0];
			go_sleep <= 1'b0;
			tick(6);
			chk(keepalive_pulse_en_o, !o[0]);
			rdchk(12'h004, 32'hC0, {o[0], 7'h40});
			wake_cmd <= 1'b1;
			tick(6);
			wake_cmd <= 1'b0;
			chk(keepalive_pulse_en_o, 1'b0);
			rdchk(12'h004, 32'hC0, 32'h0);
		end
		rdchk(12'h008, 32'h18, 32'h18);
		special_mode_i <= 1'b0;
	endtask
	task automatic t_manual;
		sleep_request_n_i <= 1'b1;
		hotswap_on_i <= 1'b1;
		tick(6);
		rdchk(12'h004, 32'h20, 32'h0);
		sleep_request_n_i <= 1'b0;
		tick(6);
		chk(keepalive_pulse_en_o, 1'b1);
		sleep_request_n_i <= 1'b1;
		tick(6);
		chk(keepalive_pulse_en_o, 1'b0);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// reset, then every scenario in turn
	initial begin
		tick(8);
		arst_n_i <= 1'b1;
		tick(2 * SC + 8);
		t_regs();
		t_ovc();
		t_short();
		t_low();
		t_special();
		t_manual();
		test_done();
	end
endmodule
